// ### sgs_defs.svh
// Register indices, field positions, reset values and timing for the gain scheduler
`ifndef SGS_DEFS_SVH
`define SGS_DEFS_SVH

// Writable register indices; byte address is four times the index
`define SGS_IDX_FILTER 4'h0
`define SGS_IDX_MODE 4'h1
`define SGS_IDX_MODEL_PG1 4'h2
`define SGS_IDX_MODEL_VG1 4'h3
`define SGS_IDX_BASE_INERTIA 4'h4
`define SGS_IDX_POS_GAIN2 4'h5
`define SGS_IDX_SPEED_GAIN2 4'h6
`define SGS_IDX_INTEGRAL 4'h7
`define SGS_IDX_CHG_INERTIA 4'h8
`define SGS_IDX_POS_PCT 4'h9
`define SGS_IDX_SPD_PCT 4'ha
`define SGS_IDX_INT_PCT 4'hb
`define SGS_IDX_SELECT 4'hc
`define SGS_IDX_THRESHOLD 4'hd
`define SGS_IDX_TIME_CONST 4'he
`define SGS_IDX_PIN_MAP 4'hf

// Read-only window: status, four effective gains, corner frequency
`define SGS_RO_SEL 3'h2
`define SGS_RO_STATUS 3'h0
`define SGS_RO_LPF_CORNER 3'h5
`define SGS_RO_LAST 3'h5

// Field positions
`define SGS_LPF_EN_BIT 0
`define SGS_MODE_LSB 4
`define SGS_MANUAL_DIGIT 4'h4
`define SGS_PIN_COUNT 6

// Reset values
`define SGS_RST_FILTER 16'h0001
`define SGS_RST_PCT 16'h0064
`define SGS_RST_OTHER 16'h0000

// Arithmetic constants
`define SGS_PCT_DIV 32'd100
`define SGS_CORNER_NUM 64'd1000000
`define SGS_TWO_PI_E4 64'd62832
`define SGS_INERTIA_OFS 64'd10

// Timing: clock period and the lag step period, in ns
`define SGS_CLK_NS 100
`define SGS_TICK_NS 1000000

`endif

// ### sgs_pkg.sv
// Types shared by the gain scheduler modules
package sgs_pkg;
	// Effective loop gain set handed to the control loop
	typedef struct packed {
		logic [15:0] inertia;
		logic [15:0] pos_gain;
		logic [15:0] spd_gain;
		logic [15:0] integ;
	} sgs_gains_t;

	// Trigger condition held in the lowest selection digit
	typedef enum logic [3:0] {
		SGS_TRIG_OFF = 4'h0,
		SGS_TRIG_PIN = 4'h1,
		SGS_TRIG_FREQ = 4'h2,
		SGS_TRIG_DROOP = 4'h3,
		SGS_TRIG_SPEED = 4'h4
	} sgs_trig_t;

	// Live measurements from the position loop
	typedef struct packed {
		logic [15:0] cmd_freq_kpps;
		logic signed [31:0] droop_pulses;
		logic signed [15:0] motor_speed;
	} sgs_meas_t;
endpackage

// ### sgs_lag.sv
// First-order lag that steers one gain toward its target once per millisecond
`timescale 1ns/100ps
module sgs_lag (
	// Clock and control
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic tick,
	// Target and time constant in ms
	input wire logic [15:0] target,
	input wire logic [15:0] tc_ms,
	// Smoothed value
	output logic [15:0] value
);
	// Accumulator with eight fraction bits so small steps are not lost
	logic [23:0] acc;
	logic signed [24:0] diff;
	logic signed [24:0] step;

	// Error and per-step move; dividing by tc gives a time constant of tc steps
	always_comb begin
		diff = $signed({1'b0, target, 8'h00}) - $signed({1'b0, acc});
		step = (tc_ms == 16'h0000) ? diff : diff / $signed({9'h000, tc_ms});
	end

	// Snap when the step rounds to zero, else the output would stall short
	always_ff @(posedge clk) begin
		if (rst) begin
			acc <= 24'h000000;
		end else if (ce && tick) begin
			if (step == 25'sh0) begin
				acc <= {target, 8'h00};
			end else begin
				acc <= 24'($signed({1'b0, acc}) + step);
			end
		end
	end

	assign value = acc[23:8];
endmodule

// ### sgs_gain_scheduler.sv
// Gain scheduler with torque low-pass corner and APB parameter registers
//
// What this block does
// - Torque low-pass filter enabled after reset
// - Corner equals speed gain scaled over inertia
// - Loop gains switch on selected trigger condition
// - Switching only in manual adjustment mode
// - Model gains never altered by switching
// - Changed state uses second inertia ratio
// - Changed gains equal base times percent/100
// - Selection digit one uses external input
// - External input mapped to one of six pins
// - Threshold read as kpps, pulses, r/min
// - Gains follow first-order lag, ms constant
// - Selection three uses droop pulse magnitude
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "sgs_defs.svh"
module sgs_gain_scheduler #(
	parameter int MS_CYCLES = `SGS_TICK_NS / `SGS_CLK_NS
) (
	// Clock, reset, clock enable
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic CE,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Gain-change pins and loop measurements
	input wire logic [5:0] GAIN_PINS,
	input wire sgs_pkg::sgs_meas_t MEAS,
	// Gains and filter setting to the control loop
	output sgs_pkg::sgs_gains_t EFF_GAINS,
	output logic [15:0] MODEL_PG1,
	output logic [15:0] MODEL_VG1,
	output logic LPF_EN,
	output logic [15:0] LPF_CORNER_HZ,
	output logic GAIN_CHANGED
);
	import sgs_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Register file and bus slave

	logic [15:0] cfg [0:15]; // Host-written parameters
	logic wr_en; // Write taken at the access edge
	logic ro_hit; // Address in the read-only window
	logic rw_hit; // Address in the writable window
	logic [31:0] next_rdata; // Read value chosen at setup
	logic [15:0] ro_val [0:5]; // Read-only values
	logic [3:0] widx;
	logic [2:0] ridx;

	// Reset value per entry: filter on, ratios at one hundred percent
	function automatic logic [15:0] rst_val(input logic [3:0] idx);
		case (idx)
			`SGS_IDX_FILTER: rst_val = `SGS_RST_FILTER;
			`SGS_IDX_POS_PCT, `SGS_IDX_SPD_PCT, `SGS_IDX_INT_PCT: rst_val = `SGS_RST_PCT;
			default: rst_val = `SGS_RST_OTHER;
		endcase
	endfunction

	assign widx = PADDR[5:2];
	assign ridx = PADDR[4:2];
	assign rw_hit = (PADDR[7:6] == 2'b00) && (PADDR[1:0] == 2'b00);
	assign ro_hit = (PADDR[7:5] == `SGS_RO_SEL) && (PADDR[1:0] == 2'b00)
		&& (ridx <= `SGS_RO_LAST);
	assign wr_en = CE && PSEL && PENABLE && PWRITE && rw_hit;

	// Zero-wait slave; a low clock enable stalls the bus with the block
	assign PREADY = CE;
	assign PSLVERR = PSEL && PENABLE && !rw_hit && !ro_hit;

	// Parameter writes; the host owns every setting including the filter bit
	always_ff @(posedge REF_CLK) begin
		for (int i = 0; i < 16; i++) begin
			if (RST) begin
				cfg[i] <= rst_val(4'(i));
			end else if (wr_en && (widx == 4'(i))) begin
				cfg[i] <= PWDATA[15:0];
			end
		end
	end

	// Read mux, evaluated during the setup phase
	always_comb begin
		next_rdata = 32'h00000000;
		if (rw_hit) begin
			next_rdata = {16'h0000, cfg[widx]};
		end else if (ro_hit) begin
			next_rdata = {16'h0000, ro_val[ridx]};
		end
	end

	// Read data registered so it is steady across the access phase
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			PRDATA <= 32'h00000000;
		end else if (CE && PSEL && !PENABLE) begin
			PRDATA <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Trigger selection

	logic [5:0] pin_meta; // First stage, read only by the second
	logic [5:0] pin_sync; // Safe pin levels
	logic manual; // Manual adjustment mode chosen
	sgs_trig_t trig;
	logic ext_on; // Mapped external input level
	logic [31:0] droop_mag;
	logic [15:0] speed_mag;
	logic cond; // Selected condition holds
	logic [15:0] thr;

	// Pins come from outside the clock domain
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			pin_meta <= 6'h00;
			pin_sync <= 6'h00;
		end else if (CE) begin
			pin_meta <= GAIN_PINS;
			pin_sync <= pin_meta;
		end
	end

	// Pin map values above five select no pin
	assign ext_on = (cfg[`SGS_IDX_PIN_MAP] < 16'(`SGS_PIN_COUNT))
		&& pin_sync[cfg[`SGS_IDX_PIN_MAP][2:0]];
	assign manual = cfg[`SGS_IDX_MODE][`SGS_MODE_LSB +: 4] == `SGS_MANUAL_DIGIT;
	assign trig = sgs_trig_t'(cfg[`SGS_IDX_SELECT][3:0]);
	assign thr = cfg[`SGS_IDX_THRESHOLD];
	assign droop_mag = MEAS.droop_pulses[31] ? 32'(-MEAS.droop_pulses) : MEAS.droop_pulses;
	assign speed_mag = MEAS.motor_speed[15] ? 16'(-MEAS.motor_speed) : MEAS.motor_speed;

	// Threshold unit follows the trigger: kpps, pulses or r/min
	always_comb begin
		case (trig)
			SGS_TRIG_PIN: cond = ext_on;
			SGS_TRIG_FREQ: cond = MEAS.cmd_freq_kpps >= thr;
			SGS_TRIG_DROOP: cond = droop_mag >= {16'h0000, thr};
			SGS_TRIG_SPEED: cond = speed_mag >= thr;
			default: cond = 1'b0;
		endcase
	end

	// Changed set while in manual mode and the condition holds, base set otherwise
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			GAIN_CHANGED <= 1'b0;
		end else if (CE) begin
			GAIN_CHANGED <= manual && cond;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Target gains and smoothing

	logic [15:0] tgt [0:3]; // Inertia, position, speed, integral targets
	logic [15:0] eff [0:3]; // Smoothed values
	logic [15:0] base [0:3];
	logic [15:0] pct [0:3];
	logic tick; // One pulse per millisecond
	int ms_cnt;

	// Scale by percent, saturating so a large ratio cannot wrap
	function automatic logic [15:0] scale(input logic [15:0] b, input logic [15:0] p);
		logic [31:0] q;
		q = (b * p) / `SGS_PCT_DIV;
		scale = (q > 32'h0000ffff) ? 16'hffff : q[15:0];
	endfunction

	assign base[0] = cfg[`SGS_IDX_BASE_INERTIA];
	assign base[1] = cfg[`SGS_IDX_POS_GAIN2];
	assign base[2] = cfg[`SGS_IDX_SPEED_GAIN2];
	assign base[3] = cfg[`SGS_IDX_INTEGRAL];
	assign pct[0] = `SGS_RST_PCT;
	assign pct[1] = cfg[`SGS_IDX_POS_PCT];
	assign pct[2] = cfg[`SGS_IDX_SPD_PCT];
	assign pct[3] = cfg[`SGS_IDX_INT_PCT];

	// Millisecond step for the lag filters
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ms_cnt <= 0;
		end else if (CE) begin
			ms_cnt <= (ms_cnt >= MS_CYCLES - 1) ? 0 : ms_cnt + 1;
		end
	end
	assign tick = ms_cnt == MS_CYCLES - 1;

	// One target and one lag per switched gain
	generate
		for (genvar g = 0; g < 4; g++) begin : gen_gain
			if (g == 0) begin : gen_inertia
				assign tgt[g] = GAIN_CHANGED ? cfg[`SGS_IDX_CHG_INERTIA] : base[g];
			end else begin : gen_ratio
				assign tgt[g] = GAIN_CHANGED ? scale(base[g], pct[g]) : base[g];
			end
			sgs_lag u_lag (
				.clk(REF_CLK),
				.rst(RST),
				.ce(CE),
				.tick(tick),
				.target(tgt[g]),
				.tc_ms(cfg[`SGS_IDX_TIME_CONST]),
				.value(eff[g])
			);
		end
	endgenerate

	// Switched gains to the loop
	assign EFF_GAINS = '{inertia: eff[0], pos_gain: eff[1], spd_gain: eff[2], integ: eff[3]};

	////////////////////////////////////////////////////////////////////////////
	// Model gains and low-pass corner

	logic [63:0] corner_q;

	// Model gains bypass the switch entirely
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			MODEL_PG1 <= 16'h0000;
			MODEL_VG1 <= 16'h0000;
		end else if (CE) begin
			MODEL_PG1 <= cfg[`SGS_IDX_MODEL_PG1];
			MODEL_VG1 <= cfg[`SGS_IDX_MODEL_VG1];
		end
	end

	// Corner = vg2*10 / (2pi*(1+J*0.1)), scaled to integers; zero while disabled
	assign corner_q = (64'(eff[2]) * `SGS_CORNER_NUM)
		/ (`SGS_TWO_PI_E4 * (`SGS_INERTIA_OFS + 64'(eff[0])));

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			LPF_EN <= 1'b1;
			LPF_CORNER_HZ <= 16'h0000;
		end else if (CE) begin
			LPF_EN <= cfg[`SGS_IDX_FILTER][`SGS_LPF_EN_BIT];
			LPF_CORNER_HZ <= cfg[`SGS_IDX_FILTER][`SGS_LPF_EN_BIT] ? corner_q[15:0] : 16'h0000;
		end
	end

	// Read-only window
	assign ro_val[0] = {14'h0000, manual, GAIN_CHANGED};
	assign ro_val[1] = eff[0];
	assign ro_val[2] = eff[1];
	assign ro_val[3] = eff[2];
	assign ro_val[4] = eff[3];
	assign ro_val[5] = LPF_CORNER_HZ;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);

	sequence s_pin_on;
		CE && manual && trig == SGS_TRIG_PIN && ext_on;
	endsequence
	sequence s_snap;
		CE && tick && cfg[`SGS_IDX_TIME_CONST] == 16'h0000;
	endsequence

	property p_lpf_reset;
		$fell(RST) |-> LPF_EN;
	endproperty
	a_lpf_reset: assert property (p_lpf_reset) else $error("filter off after reset");

	property p_corner;
		CE && LPF_EN && cfg[`SGS_IDX_FILTER][0] |=>
			LPF_CORNER_HZ == 16'((64'($past(eff[2])) * 64'd1000000)
			/ (64'd62832 * (64'd10 + 64'($past(eff[0])))));
	endproperty
	a_corner: assert property (p_corner) else $error("corner mismatch");

	property p_auto_blocks;
		CE && !manual |=> !GAIN_CHANGED;
	endproperty
	a_auto_blocks: assert property (p_auto_blocks) else $error("switch in auto mode");

	property p_model;
		$rose(GAIN_CHANGED) |-> $stable(MODEL_PG1) && $stable(MODEL_VG1);
	endproperty
	a_model: assert property (p_model) else $error("model gain moved");

	// Checked at the output so a broken target mux or lag path shows up
	property p_inertia;
		CE && tick && GAIN_CHANGED && cfg[`SGS_IDX_TIME_CONST] == 16'h0000
			|=> EFF_GAINS.inertia == $past(cfg[`SGS_IDX_CHG_INERTIA]);
	endproperty
	a_inertia: assert property (p_inertia) else $error("inertia target wrong");

	property p_pct_unity;
		pct[1] == 16'h0064 |-> tgt[1] == base[1];
	endproperty
	a_pct_unity: assert property (p_pct_unity) else $error("100 percent changed gain");

	property p_pin;
		s_pin_on |=> GAIN_CHANGED;
	endproperty
	a_pin: assert property (p_pin) else $error("pin trigger missed");

	property p_droop;
		CE && manual && trig == SGS_TRIG_DROOP && droop_mag >= {16'h0000, thr} |=> GAIN_CHANGED;
	endproperty
	a_droop: assert property (p_droop) else $error("droop trigger missed");

	property p_speed_low;
		CE && trig == SGS_TRIG_SPEED && speed_mag < thr |=> !GAIN_CHANGED;
	endproperty
	a_speed_low: assert property (p_speed_low) else $error("changed below threshold");

	property p_snap;
		s_snap |=> EFF_GAINS.pos_gain == $past(tgt[1]);
	endproperty
	a_snap: assert property (p_snap) else $error("zero time constant not direct");
endmodule

// ### sgs_host_model.sv
// Host controller model driving loop measurements and gain-change pins
`timescale 1ns/100ps
module sgs_host_model (
	// Clock
	input wire logic clk,
	// Pins and measurements toward the scheduler
	output logic [5:0] pins,
	output sgs_pkg::sgs_meas_t meas
);
	import sgs_pkg::*;
	////////////////////////////////////////////////////////////////////////////
	// Idle: no pin asserted, loop at rest
	initial begin
		pins = 6'h00;
		meas = '0;
	end
	// New measurements land just after an edge, like a real loop update
	task set_meas(input logic [15:0] f, input logic [31:0] d, input logic [15:0] s);
		@(posedge clk);
		meas <= '{f, d, s};
	endtask
	// Pin levels, one bit per pin; the scheduler synchronises them
	task set_pins(input logic [5:0] p);
		@(posedge clk);
		pins <= p;
	endtask
endmodule

// ### tb_sgs_gain_scheduler.sv
// Self-checking bench for the gain scheduler
`timescale 1ns/100ps
module tb_sgs_gain_scheduler;
	import sgs_pkg::*;
	logic ref_clk, rst, ce, psel, penable, pwrite, pready, pslverr, lpf_en, changed, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0] pins;
	logic [15:0] mpg1, mvg1, corner, thr;
	logic [3:0] sel;
	logic signed [31:0] val;
	logic hit;
	sgs_meas_t meas;
	sgs_gains_t eff, base_set, chg_set, exp_set;
	int failures, total_checks, seed, i;
	// Parameter set used by every scenario: address and value pairs
	logic [7:0] cfg_a [12] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
		8'h24, 8'h28, 8'h2c, 8'h38};
	logic [15:0] cfg_d [12] = '{16'h0040, 16'h0064, 16'h03e8, 16'h0028, 16'h0078, 16'h0bb8,
		16'h0014, 16'h0064, 16'h0046, 16'h0085, 16'h00fa, 16'h0000};
	////////////////////////////////////////////////////////////////////////////
	// Short lag period keeps the run brief
	sgs_gain_scheduler #(.MS_CYCLES(4)) dut (.REF_CLK(ref_clk), .RST(rst), .CE(ce),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .GAIN_PINS(pins), .MEAS(meas),
		.EFF_GAINS(eff), .MODEL_PG1(mpg1), .MODEL_VG1(mvg1), .LPF_EN(lpf_en),
		.LPF_CORNER_HZ(corner), .GAIN_CHANGED(changed));
	sgs_host_model host (.clk(ref_clk), .pins(pins), .meas(meas));
	// 10 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////////
	// Percent scaling with saturation at the field limit
	function automatic logic [15:0] pct(input logic [15:0] b, input logic [15:0] p);
		logic [31:0] t;
		t = 32'(b) * 32'(p) / 32'd100;
		return (t > 32'h0000ffff) ? 16'hffff : t[15:0];
	endfunction
	// Corner in Hz from speed gain and inertia ratio in tenths
	function automatic logic [15:0] corner_of(input sgs_gains_t g);
		logic [63:0] q;
		q = 64'(g.spd_gain) * 64'd1000000 / (64'd62832 * (64'd10 + 64'(g.inertia)));
		return q[15:0];
	endfunction
	task tally_and_finish;
		if (failures == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One APB transfer; the wait for ready is bounded so a dead slave ends the run
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			failures++;
			tally_and_finish();
		end
	endtask
	task wait_settle;
		repeat (20) @(posedge ref_clk);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		seed = 32'h835b;
		failures = 0;
		total_checks = 0;
		{rst, ce, psel, penable, pwrite, paddr, pwdata} = {1'b1, 1'b1, 43'h0};
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk("lpf_en", 64'h1, 64'(lpf_en));
		apb(1'b0, 8'h00, 32'h0);
		chk("filter_reg", 64'h1, 64'(rd));
		apb(1'b0, 8'h24, 32'h0);
		chk("pos_pct_reg", 64'h64, 64'(rd));
		apb(1'b0, 8'h58, 32'h0);
		chk("unmapped_err", 64'h1, 64'(err));
		for (i = 0; i < 12; i++) begin
			apb(1'b1, cfg_a[i], 32'(cfg_d[i]));
		end
		base_set = '{16'd40, 16'd120, 16'd3000, 16'd20};
		chg_set = '{16'd100, pct(120, 70), pct(3000, 133), pct(20, 250)};
		wait_settle();
		chk("model_pg1", 64'd100, 64'(mpg1));
		chk("model_vg1", 64'd1000, 64'(mvg1));
		chk("eff_gains", 64'(base_set), 64'(eff));
		chk("corner", 64'(corner_of(base_set)), 64'(corner));
		// Random thresholds around the boundary for each measured trigger
		for (i = 0; i < 9; i++) begin
			sel = 4'(2 + i % 3);
			thr = 16'(1 + $unsigned($random(seed)) % 30000);
			val = 32'(thr) - 1 + $unsigned($random(seed)) % 3;
			if (sel != 4'h2 && $random(seed) % 2 == 0) begin
				val = -val;
			end
			hit = ((val < 0) ? -val : val) >= 32'(thr);
			apb(1'b1, 8'h30, 32'(sel));
			apb(1'b1, 8'h34, 32'(thr));
			host.set_meas((sel == 4'h2) ? val[15:0] : 16'h0, (sel == 4'h3) ? val : 32'h0,
				(sel == 4'h4) ? val[15:0] : 16'h0);
			wait_settle();
			exp_set = hit ? chg_set : base_set;
			chk("gain_changed", 64'(hit), 64'(changed));
			chk("eff_gains", 64'(exp_set), 64'(eff));
			chk("corner", 64'(corner_of(exp_set)), 64'(corner));
		end
		// External input on each mapped pin, other pins must not count
		apb(1'b1, 8'h30, 32'h1);
		host.set_meas(16'h0, 32'h0, 16'h0);
		for (i = 0; i < 6; i++) begin
			apb(1'b1, 8'h3c, 32'(i));
			host.set_pins(6'h01 << i);
			wait_settle();
			chk("pin_changed", 64'h1, 64'(changed));
			host.set_pins(~(6'h01 << i));
			wait_settle();
			chk("pin_changed", 64'h0, 64'(changed));
		end
		// Condition true but adjustment mode not manual
		host.set_pins(6'h00);
		apb(1'b1, 8'h30, 32'h3);
		apb(1'b1, 8'h34, 32'h32);
		host.set_meas(16'h0, 32'h3c, 16'h0);
		apb(1'b1, 8'h04, 32'h0);
		wait_settle();
		chk("gain_changed", 64'h0, 64'(changed));
		chk("eff_gains", 64'(base_set), 64'(eff));
		apb(1'b1, 8'h04, 32'h40);
		wait_settle();
		chk("gain_changed", 64'h1, 64'(changed));
		// Slow lag: speed gain must sit between old and new after a few ticks
		host.set_meas(16'h0, 32'h0, 16'h0);
		wait_settle();
		apb(1'b1, 8'h38, 32'h64);
		host.set_meas(16'h0, 32'h3c, 16'h0);
		repeat (12) @(posedge ref_clk);
		chk("spd_moving", 64'h1, 64'(eff.spd_gain > 16'd3000 && eff.spd_gain < 16'd3990));
		// Clock enable low freezes the switch and the lag, and stalls the bus
		@(posedge ref_clk);
		ce <= 1'b0;
		host.set_meas(16'h0, 32'h0, 16'h0);
		exp_set = eff;
		repeat (10) @(posedge ref_clk);
		chk("ce_hold", 64'h1, 64'(changed));
		chk("ce_eff", 64'(exp_set), 64'(eff));
		chk("ce_ready", 64'h0, 64'(pready));
		ce <= 1'b1;
		wait_settle();
		chk("gain_changed", 64'h0, 64'(changed));
		// Selection code zero never switches, and the status word shows it
		apb(1'b1, 8'h30, 32'h0);
		host.set_meas(16'h0, 32'h3c, 16'h0);
		wait_settle();
		chk("gain_changed", 64'h0, 64'(changed));
		apb(1'b0, 8'h40, 32'h0);
		chk("status_reg", 64'h2, 64'(rd));
		// Host turns the torque filter off
		apb(1'b1, 8'h00, 32'h0);
		repeat (3) @(posedge ref_clk);
		chk("lpf_en", 64'h0, 64'(lpf_en));
		chk("corner", 64'h0, 64'(corner));
		tally_and_finish();
	end
endmodule
